// ### icu_top.sv
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// RULE_01: code 0110 compares signed operands, true when first is less or equal.
// RULE_02: code 0111 compares zero-extended operands, true when first is less or equal.
// RULE_03: code 1000 compares signed operands, true when first is strictly less.
// RULE_04: code 1001 compares zero-extended operands, true when first is strictly less.
// RULE_05: code 0001 is true when the two 32-bit operands differ.
// RULE_06: compares have bits 29:28 zero, bit 26 set, code 24:21, source 5:0.
// RULE_07: register form to general register: destination 17:12, second source 11:6.
// RULE_08: register form to branch register: destination 20:18, one result bit.
// RULE_09: immediate form to general register: immediate 20:12, destination 11:6.
// RULE_10: immediate form to branch register: immediate 20:12, destination 8:6.
// RULE_11: signed and inequality compares sign-extend the short immediate to 32 bits.
// RULE_12: compares are accepted every cycle, back to back, without latency limits.
// RULE_13: an accompanying extension's 23 bits join the short immediate as 32 bits.
// RULE_14: an extension may precede the compare or follow it; both are accepted.
// RULE_15: a general register result is the word one for true, zero for false.
// RULE_16: no exception ever; nothing is written unless a compare form decodes.
module icu_top (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // issue side
  input wire logic op_valid_i,
  input wire logic [31:0] op_word_i,
  input wire logic ext_valid_i,
  input wire logic [31:0] ext_word_i,
  input wire logic [icu_pkg::XLEN-1:0] first_source_index_val_i,
  input wire logic [icu_pkg::XLEN-1:0] second_source_index_val_i,
  // result side
  output logic gr_we_o,
  output logic [icu_pkg::GR_W-1:0] gr_idx_o,
  output logic [icu_pkg::XLEN-1:0] gr_data_o,
  output logic br_we_o,
  output logic [icu_pkg::BR_W-1:0] br_idx_o,
  output logic br_data_o,
  output logic [icu_pkg::GR_W-1:0] first_source_index_idx_o,
  output logic [icu_pkg::GR_W-1:0] second_source_index_idx_o,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // ==========================================================
  // decode and compare
  icu_dec_if dif();

  logic en_r;
  logic pend_r;
  logic [icu_pkg::EXT_W-1:0] pend_val_r;
  logic ext_prev_ok;
  logic ext_use;
  logic [icu_pkg::EXT_W-1:0] ext_val;
  logic accept;
  logic [icu_pkg::XLEN-1:0] op_b;
  logic res;
  logic last_r;
  icu_pkg::icu_opc_t last_opc_r;
  logic [31:0] cnt_r;
  logic [31:0] true_r;

  // accompanying extension wins over a held one; both carry 23 bits
  assign ext_prev_ok = ext_valid_i
                       && (ext_word_i[icu_pkg::CLS_HI:icu_pkg::CLS_LO] == icu_pkg::CLS_EXT)
                       && (ext_word_i[icu_pkg::EXT_OP_HI:icu_pkg::EXT_OP_LO]
                           == icu_pkg::EXT_PREV); // RULE_14
  assign ext_use = ext_prev_ok || pend_r; // RULE_14
  assign ext_val = ext_prev_ok ? ext_word_i[icu_pkg::EXT_HI:icu_pkg::EXT_LO] : pend_val_r;

  icu_decoder u_dec (
    .word_i(op_word_i),
    .ext_use_i(ext_use),
    .ext_i(ext_val),
    .d(dif.dec)
  );

  assign op_b = dif.imm_form ? dif.imm : second_source_index_val_i;

  icu_cmp u_cmp (
    .opc_i(dif.opc),
    .a_i(first_source_index_val_i),
    .b_i(op_b),
    .res_o(res)
  );

  // no slot or spacing checks: any valid compare is taken while ce_i and en_r are high
  assign accept = ce_i && en_r && op_valid_i && dif.is_cmp; // RULE_12

  // ==========================================================
  // extension held for the following syllable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r <= 1'b0;
      pend_val_r <= '0;
    end else if (ce_i && op_valid_i) begin
      if (dif.is_ext_next) begin
        pend_r <= 1'b1; // RULE_14
        pend_val_r <= op_word_i[icu_pkg::EXT_HI:icu_pkg::EXT_LO];
      end else begin
        pend_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // result registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gr_we_o <= 1'b0;
      br_we_o <= 1'b0;
      gr_idx_o <= '0;
      br_idx_o <= '0;
      gr_data_o <= '0;
      br_data_o <= 1'b0;
      first_source_index_idx_o <= '0;
      second_source_index_idx_o <= '0;
    end else if (ce_i) begin
      // other forms and non-compare words never write
      gr_we_o <= accept && !dif.br_form; // RULE_16 RULE_07 RULE_09
      br_we_o <= accept && dif.br_form; // RULE_16 RULE_08 RULE_10
      if (accept) begin
        gr_idx_o <= dif.gr_dst; // RULE_07 RULE_09
        br_idx_o <= dif.br_dst; // RULE_08 RULE_10
        gr_data_o <= {{(icu_pkg::XLEN - 1){1'b0}}, res}; // RULE_15
        br_data_o <= res; // RULE_08
        first_source_index_idx_o <= dif.first_source_index;
        second_source_index_idx_o <= dif.second_source_index;
      end
    end
  end

  // ==========================================================
  // observed state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_r <= 1'b0;
      last_opc_r <= icu_pkg::ICU_NE;
    end else if (accept) begin
      last_r <= res;
      last_opc_r <= dif.opc;
    end
  end

  // ==========================================================
  // wishbone slave: one wait state, ack for one cycle
  logic wb_req;
  logic wb_wr;
  logic clr_req;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = ce_i && wb_req && wb_we_i && wb_sel_i[0];
  assign clr_req = wb_wr && (wb_adr_i == icu_pkg::REG_CTRL) && wb_dat_i[icu_pkg::CTRL_CLR];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_r <= icu_pkg::CTRL_EN_RST;
    end else if (wb_wr && (wb_adr_i == icu_pkg::REG_CTRL)) begin
      en_r <= wb_dat_i[icu_pkg::CTRL_EN];
    end
  end

  // a clear in the same cycle as a compare restarts the counts from that compare
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= icu_pkg::CNT_RST;
      true_r <= icu_pkg::CNT_RST;
    end else if (accept) begin
      cnt_r <= clr_req ? 32'h00000001 : cnt_r + 32'h00000001;
      true_r <= clr_req ? {31'h00000000, res} : true_r + {31'h00000000, res};
    end else if (clr_req) begin
      cnt_r <= icu_pkg::CNT_RST;
      true_r <= icu_pkg::CNT_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (ce_i && wb_req && !wb_we_i) begin
      case (wb_adr_i)
        icu_pkg::REG_CTRL: wb_dat_o <= {31'h00000000, en_r};
        icu_pkg::REG_STAT: wb_dat_o <= {24'h000000, last_opc_r, 2'h0, pend_r, last_r};
        icu_pkg::REG_COUNT: wb_dat_o <= cnt_r;
        icu_pkg::REG_TRUE: wb_dat_o <= true_r;
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // checks
  logic out_bit;
  logic [icu_pkg::XLEN-1:0] sext_imm;
  logic rr_gr;
  logic rr_br;
  logic ri_gr;
  logic ri_br;

  assign out_bit = gr_we_o ? gr_data_o[0] : br_data_o;
  assign sext_imm = {{(icu_pkg::XLEN - icu_pkg::SIMM_W){op_word_i[icu_pkg::IMM_HI]}},
                     op_word_i[icu_pkg::IMM_HI:icu_pkg::IMM_LO]};
  assign rr_gr = accept && !dif.imm_form && !dif.br_form;
  assign rr_br = accept && !dif.imm_form && dif.br_form;
  assign ri_gr = accept && dif.imm_form && !dif.br_form;
  assign ri_br = accept && dif.imm_form && dif.br_form;

  property p_le_signed;
    @(posedge clk_i) disable iff (rst_i)
    accept && dif.opc == icu_pkg::ICU_LE |=>
      out_bit == ($signed($past(first_source_index_val_i)) <= $signed($past(op_b)));
  endproperty
  a_le_signed: assert property (p_le_signed) else $error("signed le wrong"); // RULE_01

  property p_le_unsigned;
    @(posedge clk_i) disable iff (rst_i)
    accept && dif.opc == icu_pkg::ICU_LEU |=> out_bit == ($past(first_source_index_val_i) <= $past(op_b));
  endproperty
  a_le_unsigned: assert property (p_le_unsigned) else $error("unsigned le wrong"); // RULE_02

  property p_lt_signed;
    @(posedge clk_i) disable iff (rst_i)
    accept && dif.opc == icu_pkg::ICU_LT |=>
      out_bit == ($signed($past(first_source_index_val_i)) < $signed($past(op_b)));
  endproperty
  a_lt_signed: assert property (p_lt_signed) else $error("signed lt wrong"); // RULE_03

  property p_lt_unsigned;
    @(posedge clk_i) disable iff (rst_i)
    accept && dif.opc == icu_pkg::ICU_LTU |=> out_bit == ($past(first_source_index_val_i) < $past(op_b));
  endproperty
  a_lt_unsigned: assert property (p_lt_unsigned) else $error("unsigned lt wrong"); // RULE_04

  property p_ne;
    @(posedge clk_i) disable iff (rst_i)
    accept && dif.opc == icu_pkg::ICU_NE |=> out_bit == ($past(first_source_index_val_i) != $past(op_b));
  endproperty
  a_ne: assert property (p_ne) else $error("inequality wrong"); // RULE_05

  property p_rr_gr;
    @(posedge clk_i) disable iff (rst_i)
    rr_gr |=> gr_we_o && !br_we_o
      && gr_idx_o == $past(op_word_i[icu_pkg::RR_GR_DST_HI:icu_pkg::RR_GR_DST_LO])
      && second_source_index_idx_o == $past(op_word_i[icu_pkg::SECOND_SOURCE_INDEX_HI:icu_pkg::SECOND_SOURCE_INDEX_LO]);
  endproperty
  a_rr_gr: assert property (p_rr_gr) else $error("rr general dest wrong"); // RULE_07

  property p_rr_br;
    @(posedge clk_i) disable iff (rst_i)
    rr_br |=> br_we_o && !gr_we_o
      && br_idx_o == $past(op_word_i[icu_pkg::RR_BR_DST_HI:icu_pkg::RR_BR_DST_LO]);
  endproperty
  a_rr_br: assert property (p_rr_br) else $error("rr branch dest wrong"); // RULE_08

  property p_ri_gr;
    @(posedge clk_i) disable iff (rst_i)
    ri_gr |=> gr_we_o
      && gr_idx_o == $past(op_word_i[icu_pkg::RI_GR_DST_HI:icu_pkg::RI_GR_DST_LO]);
  endproperty
  a_ri_gr: assert property (p_ri_gr) else $error("ri general dest wrong"); // RULE_09

  property p_ri_br;
    @(posedge clk_i) disable iff (rst_i)
    ri_br |=> br_we_o
      && br_idx_o == $past(op_word_i[icu_pkg::RI_BR_DST_HI:icu_pkg::RI_BR_DST_LO]);
  endproperty
  a_ri_br: assert property (p_ri_br) else $error("ri branch dest wrong"); // RULE_10

  property p_imm_sext;
    @(posedge clk_i) disable iff (rst_i)
    dif.imm_form && !ext_use && dif.opc != icu_pkg::ICU_LEU && dif.opc != icu_pkg::ICU_LTU
      |-> dif.imm == sext_imm;
  endproperty
  a_imm_sext: assert property (p_imm_sext) else $error("immediate not sign-extended"); // RULE_11

  property p_imm_ext;
    @(posedge clk_i) disable iff (rst_i)
    dif.imm_form && ext_use |->
      dif.imm[icu_pkg::XLEN-1:icu_pkg::SIMM_W] == ext_val
      && dif.imm[icu_pkg::SIMM_W-1:0] == op_word_i[icu_pkg::IMM_HI:icu_pkg::IMM_LO];
  endproperty
  a_imm_ext: assert property (p_imm_ext) else $error("extended immediate wrong"); // RULE_13

  property p_back_to_back;
    @(posedge clk_i) disable iff (rst_i)
    accept ##1 accept |=> gr_we_o || br_we_o;
  endproperty
  a_back_to_back: assert property (p_back_to_back) else $error("second compare lost"); // RULE_12

  property p_pending;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && op_valid_i && dif.is_ext_next |=> pend_r ##0 ext_use;
  endproperty
  a_pending: assert property (p_pending) else $error("held extension lost"); // RULE_14

  property p_word_one_zero;
    @(posedge clk_i) disable iff (rst_i)
    gr_we_o |-> gr_data_o[icu_pkg::XLEN-1:1] == '0;
  endproperty
  a_word_one_zero: assert property (p_word_one_zero) else $error("result not 0/1"); // RULE_15

  property p_no_write;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && !accept |=> !gr_we_o && !br_we_o;
  endproperty
  a_no_write: assert property (p_no_write) else $error("write without compare"); // RULE_16

  c_imm_branch: cover property (@(posedge clk_i) disable iff (rst_i) ri_br);
  c_ext_next: cover property (@(posedge clk_i) disable iff (rst_i) pend_r && accept);
  c_ext_prev: cover property (@(posedge clk_i) disable iff (rst_i) ext_prev_ok && accept);
  c_wb_read: cover property (@(posedge clk_i) disable iff (rst_i) wb_ack_o && !wb_we_i);

endmodule

// ### icu_pkg.sv
package icu_pkg;

  // ==========================================================
  // operation word layout
  localparam int unsigned CLS_HI = 29;
  localparam int unsigned CLS_LO = 28;
  localparam int unsigned IMM_FORM_BIT = 27;
  localparam int unsigned CMP_BIT = 26;
  localparam int unsigned BR_FORM_BIT = 25;
  localparam int unsigned OPC_HI = 24;
  localparam int unsigned OPC_LO = 21;
  localparam int unsigned RR_GR_DST_HI = 17;
  localparam int unsigned RR_GR_DST_LO = 12;
  localparam int unsigned RR_BR_DST_HI = 20;
  localparam int unsigned RR_BR_DST_LO = 18;
  localparam int unsigned SECOND_SOURCE_INDEX_HI = 11;
  localparam int unsigned SECOND_SOURCE_INDEX_LO = 6;
  localparam int unsigned IMM_HI = 20;
  localparam int unsigned IMM_LO = 12;
  localparam int unsigned RI_GR_DST_HI = 11;
  localparam int unsigned RI_GR_DST_LO = 6;
  localparam int unsigned RI_BR_DST_HI = 8;
  localparam int unsigned RI_BR_DST_LO = 6;
  localparam int unsigned FIRST_SOURCE_INDEX_HI = 5;
  localparam int unsigned FIRST_SOURCE_INDEX_LO = 0;
  localparam int unsigned EXT_OP_HI = 27;
  localparam int unsigned EXT_OP_LO = 23;
  localparam int unsigned EXT_HI = 22;
  localparam int unsigned EXT_LO = 0;

  // ==========================================================
  // widths and codes
  localparam int unsigned XLEN = 32;
  localparam int unsigned GR_W = 6;
  localparam int unsigned BR_W = 3;
  localparam int unsigned SIMM_W = 9;
  localparam int unsigned EXT_W = 23;
  localparam logic [1:0] CLS_CMP = 2'h0;
  localparam logic [1:0] CLS_EXT = 2'h1;
  localparam logic [4:0] EXT_PREV = 5'h0A;
  localparam logic [4:0] EXT_NEXT = 5'h0B;

  typedef enum logic [3:0] {
    ICU_NE  = 4'h1,
    ICU_LE  = 4'h6,
    ICU_LEU = 4'h7,
    ICU_LT  = 4'h8,
    ICU_LTU = 4'h9
  } icu_opc_t;

  // ==========================================================
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_COUNT = 8'h08;
  localparam logic [7:0] REG_TRUE = 8'h0C;
  localparam int unsigned CTRL_EN = 0;
  localparam int unsigned CTRL_CLR = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int unsigned STAT_LAST = 0;
  localparam int unsigned STAT_PEND = 1;
  localparam int unsigned STAT_OPC_LO = 4;
  localparam logic [31:0] CNT_RST = 32'h00000000;

endpackage

// ### icu_dec_if.sv
`timescale 1ns/1ps
interface icu_dec_if;
  logic is_cmp;
  logic is_ext_next;
  logic imm_form;
  logic br_form;
  icu_pkg::icu_opc_t opc;
  logic [icu_pkg::GR_W-1:0] gr_dst;
  logic [icu_pkg::BR_W-1:0] br_dst;
  logic [icu_pkg::GR_W-1:0] first_source_index;
  logic [icu_pkg::GR_W-1:0] second_source_index;
  logic [icu_pkg::XLEN-1:0] imm;

  modport dec (
    output is_cmp, is_ext_next, imm_form, br_form, opc, gr_dst, br_dst, first_source_index, second_source_index, imm
  );
  modport sink (
    input is_cmp, is_ext_next, imm_form, br_form, opc, gr_dst, br_dst, first_source_index, second_source_index, imm
  );
endinterface

// ### icu_decoder.sv
`timescale 1ns/1ps
module icu_decoder (
  // syllable and extension
  input wire logic [31:0] word_i,
  input wire logic ext_use_i,
  input wire logic [icu_pkg::EXT_W-1:0] ext_i,
  // decoded fields
  icu_dec_if.dec d
);
  logic [3:0] opc_raw;
  logic opc_ok;
  logic [icu_pkg::SIMM_W-1:0] simm;
  logic sext;

  assign opc_raw = word_i[icu_pkg::OPC_HI:icu_pkg::OPC_LO];
  assign simm = word_i[icu_pkg::IMM_HI:icu_pkg::IMM_LO];

  always_comb begin
    case (opc_raw)
      icu_pkg::ICU_NE, icu_pkg::ICU_LE, icu_pkg::ICU_LEU,
      icu_pkg::ICU_LT, icu_pkg::ICU_LTU: opc_ok = 1'b1;
      default: opc_ok = 1'b0;
    endcase
  end

  // class, compare bit and a known code; other codes stay out of this unit
  assign d.is_cmp = (word_i[icu_pkg::CLS_HI:icu_pkg::CLS_LO] == icu_pkg::CLS_CMP)
                    && word_i[icu_pkg::CMP_BIT] && opc_ok; // RULE_06
  assign d.is_ext_next = (word_i[icu_pkg::CLS_HI:icu_pkg::CLS_LO] == icu_pkg::CLS_EXT)
                         && (word_i[icu_pkg::EXT_OP_HI:icu_pkg::EXT_OP_LO]
                             == icu_pkg::EXT_NEXT); // RULE_14
  assign d.opc = icu_pkg::icu_opc_t'(opc_raw); // RULE_06
  assign d.imm_form = word_i[icu_pkg::IMM_FORM_BIT];
  assign d.br_form = word_i[icu_pkg::BR_FORM_BIT];
  assign d.first_source_index = word_i[icu_pkg::FIRST_SOURCE_INDEX_HI:icu_pkg::FIRST_SOURCE_INDEX_LO]; // RULE_06
  assign d.second_source_index = word_i[icu_pkg::SECOND_SOURCE_INDEX_HI:icu_pkg::SECOND_SOURCE_INDEX_LO]; // RULE_07
  // destination field moves with the form
  assign d.gr_dst = word_i[icu_pkg::IMM_FORM_BIT]
                    ? word_i[icu_pkg::RI_GR_DST_HI:icu_pkg::RI_GR_DST_LO] // RULE_09
                    : word_i[icu_pkg::RR_GR_DST_HI:icu_pkg::RR_GR_DST_LO]; // RULE_07
  assign d.br_dst = word_i[icu_pkg::IMM_FORM_BIT]
                    ? word_i[icu_pkg::RI_BR_DST_HI:icu_pkg::RI_BR_DST_LO] // RULE_10
                    : word_i[icu_pkg::RR_BR_DST_HI:icu_pkg::RR_BR_DST_LO]; // RULE_08

  // unsigned codes zero-extend, signed and inequality sign-extend
  assign sext = (opc_raw != icu_pkg::ICU_LEU) && (opc_raw != icu_pkg::ICU_LTU); // RULE_11
  assign d.imm = ext_use_i ? {ext_i, simm} // RULE_13
               : {{(icu_pkg::XLEN - icu_pkg::SIMM_W){sext & simm[icu_pkg::SIMM_W-1]}},
                  simm}; // RULE_11 RULE_02 RULE_04
endmodule

// ### icu_cmp.sv
`timescale 1ns/1ps
module icu_cmp (
  // operation and operands
  input wire icu_pkg::icu_opc_t opc_i,
  input wire logic [icu_pkg::XLEN-1:0] a_i,
  input wire logic [icu_pkg::XLEN-1:0] b_i,
  // outcome
  output logic res_o
);
  logic lt_s;
  logic lt_u;
  logic eq;

  // no overflow trap: plain comparators cannot fault
  assign lt_s = $signed(a_i) < $signed(b_i);
  assign lt_u = a_i < b_i;
  assign eq = a_i == b_i;

  always_comb begin
    case (opc_i)
      icu_pkg::ICU_LE: res_o = lt_s | eq; // RULE_01
      icu_pkg::ICU_LEU: res_o = lt_u | eq; // RULE_02
      icu_pkg::ICU_LT: res_o = lt_s; // RULE_03
      icu_pkg::ICU_LTU: res_o = lt_u; // RULE_04
      icu_pkg::ICU_NE: res_o = ~eq; // RULE_05
      default: res_o = 1'b0;
    endcase
  end
endmodule

// ### icu_issue_model.sv
`timescale 1ns/1ps
module icu_issue_model (
  // clock
  input wire logic clk_i,
  // issue side
  input wire logic [31:0] word_i,
  output logic [31:0] first_source_index_val_o,
  output logic [31:0] second_source_index_val_o,
  // result side
  input wire logic gr_we_i,
  input wire logic [5:0] gr_idx_i,
  input wire logic [31:0] gr_data_i,
  input wire logic br_we_i,
  input wire logic [2:0] br_idx_i,
  input wire logic br_data_i
);
  // ==========================================================
  // register files; gr is loaded by the bench before each compare whose result it checks
  logic [31:0] gr [64];
  logic br [8];

  initial begin
    for (int k = 0; k < 64; k++) begin
      gr[k] = 32'h5A5A0000 + 32'(k);
    end
  end

  // operands read straight from the word's index fields, same cycle
  assign first_source_index_val_o = gr[word_i[5:0]];
  assign second_source_index_val_o = gr[word_i[11:6]];

  // ==========================================================
  // writeback; plain always since the bench also loads entries
  always @(posedge clk_i) begin
    if (gr_we_i) begin
      gr[gr_idx_i] <= gr_data_i;
    end
    if (br_we_i) begin
      br[br_idx_i] <= br_data_i;
    end
  end
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb;
  // ==========================================================
  // signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic op_valid_i = 1'b0;
  logic [31:0] op_word_i = 32'h0;
  logic ext_valid_i = 1'b0;
  logic [31:0] ext_word_i = 32'h0;
  logic [31:0] first_source_index_val_i, second_source_index_val_i;
  logic gr_we_o, br_we_o, br_data_o, wb_ack_o;
  logic [5:0] gr_idx_o, first_source_index_idx_o, second_source_index_idx_o;
  logic [2:0] br_idx_o;
  logic [31:0] gr_data_o, wb_dat_o;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  int mismatches = 0;
  int num_checks = 0;
  logic [3:0] codes [5] = '{4'h1, 4'h6, 4'h7, 4'h8, 4'h9};

  always #12.5 clk_i = ~clk_i;

  icu_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .op_valid_i(op_valid_i),
    .op_word_i(op_word_i), .ext_valid_i(ext_valid_i), .ext_word_i(ext_word_i),
    .first_source_index_val_i(first_source_index_val_i), .second_source_index_val_i(second_source_index_val_i), .gr_we_o(gr_we_o),
    .gr_idx_o(gr_idx_o), .gr_data_o(gr_data_o), .br_we_o(br_we_o), .br_idx_o(br_idx_o),
    .br_data_o(br_data_o), .first_source_index_idx_o(first_source_index_idx_o), .second_source_index_idx_o(second_source_index_idx_o),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

  icu_issue_model i_model (.clk_i(clk_i), .word_i(op_word_i), .first_source_index_val_o(first_source_index_val_i),
    .second_source_index_val_o(second_source_index_val_i), .gr_we_i(gr_we_o), .gr_idx_i(gr_idx_o),
    .gr_data_i(gr_data_o), .br_we_i(br_we_o), .br_idx_i(br_idx_o), .br_data_i(br_data_o));

  // ==========================================================
  // helpers
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] mk(logic i, logic b, logic [3:0] o, logic [14:0] m);
    return {4'h0, i, 1'b1, b, o, m, 6'h03};
  endfunction

  function automatic logic exp_res(logic [3:0] o, logic [31:0] a, logic [31:0] b);
    case (o)
      4'h1: return a != b;
      4'h6: return $signed(a) <= $signed(b);
      4'h7: return a <= b;
      4'h8: return $signed(a) < $signed(b);
      default: return a < b;
    endcase
  endfunction

  // one syllable in, valid dropped at the taking edge; outputs settled on return
  task automatic issue(input logic [31:0] w, input logic ev, input logic [31:0] ew);
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    op_word_i <= w;
    ext_valid_i <= ev;
    ext_word_i <= ew;
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    ext_valid_i <= 1'b0;
    #1;
  endtask

  task automatic no_write();
    chk(32'(gr_we_o | br_we_o), 32'h0);
  endtask

  task automatic wb_io(input logic we, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    chk(32'(wb_ack_o), 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  // ext: 0 none, 1 accompanying, 2 preceding
  task automatic cmp_case(input logic i, input logic b, input logic [3:0] o,
      input logic [31:0] av, input logic [31:0] bv, input logic [8:0] imm,
      input logic [1:0] ext, input logic [22:0] pay);
    logic [14:0] m;
    logic [31:0] op2;
    logic e;
    i_model.gr[3] = av;
    i_model.gr[4] = bv;
    if (!i) m = b ? {3'h5, 6'h00, 6'h04} : {3'h0, 6'h2A, 6'h04};
    else m = b ? {imm, 3'h0, 3'h5} : {imm, 6'h2A};
    if (!i) op2 = bv;
    else if (ext != 2'h0) op2 = {pay, imm};
    else if (o == 4'h7 || o == 4'h9) op2 = {23'h0, imm};
    else op2 = {{23{imm[8]}}, imm};
    e = exp_res(o, av, op2);
    if (ext == 2'h2) begin
      issue({4'h1, 5'h0B, pay}, 1'b0, 32'h0);
      no_write();
    end
    issue(mk(i, b, o, m), ext == 2'h1, {4'h1, 5'h0A, pay});
    chk(32'(first_source_index_idx_o), 32'h3);
    if (!i) chk(32'(second_source_index_idx_o), 32'h4);
    if (b) begin
      chk(32'(br_we_o), 32'h1);
      chk(32'(br_idx_o), 32'h5);
      chk(32'(br_data_o), 32'(e));
      chk(32'(gr_we_o), 32'h0);
    end else begin
      chk(32'(gr_we_o), 32'h1);
      chk(32'(gr_idx_o), 32'h2A);
      chk(gr_data_o, 32'(e));
      chk(32'(br_we_o), 32'h0);
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [31:0] q;
    chk(32'({gr_we_o, br_we_o}), 32'h0);
    chk(gr_data_o, 32'h0);
    wb_io(1'b0, 8'h00, 32'h0, q);
    chk(q & 32'h1, 32'h1);
    wb_io(1'b0, 8'h08, 32'h0, q);
    chk(q, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_codes();
    for (int c = 0; c < 5; c++) begin
      for (int f = 0; f < 4; f++) begin
        cmp_case(f[1], f[0], codes[c], 32'hFFFFFFFF, 32'h1, 9'h1FF, 2'h0, 23'h0);
        cmp_case(f[1], f[0], codes[c], 32'h5, 32'h5, 9'h005, 2'h0, 23'h0);
        cmp_case(f[1], f[0], codes[c], 32'h7FFFFFFF, 32'h80000000, 9'h100, 2'h0, 23'h0);
      end
    end
    $display("test codes done");
  endtask

  task automatic t_ext();
    cmp_case(1'b1, 1'b0, 4'h9, 32'h12345678, 32'h0, 9'h0AB, 2'h1, 23'h091A2B);
    cmp_case(1'b1, 1'b0, 4'h1, 32'h000001FF, 32'h0, 9'h1FF, 2'h1, 23'h0);
    cmp_case(1'b1, 1'b1, 4'h6, 32'h80000000, 32'h0, 9'h1FF, 2'h2, 23'h400000);
    $display("test extension done");
  endtask

  task automatic t_b2b();
    i_model.gr[3] = 32'h5;
    i_model.gr[4] = 32'h6;
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    op_word_i <= mk(1'b0, 1'b0, 4'h8, {3'h0, 6'h2A, 6'h04});
    @(posedge clk_i);
    op_word_i <= mk(1'b0, 1'b1, 4'h1, {3'h5, 6'h00, 6'h03});
    #1;
    chk(32'({gr_we_o, br_we_o}), 32'h2);
    chk(gr_data_o, 32'h1);
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    #1;
    chk(32'({gr_we_o, br_we_o, br_data_o}), 32'h2);
    @(posedge clk_i);
    #1;
    no_write();
    $display("test back to back done");
  endtask

  task automatic t_refuse();
    logic [31:0] q;
    logic [31:0] w;
    w = mk(1'b0, 1'b0, 4'h8, {3'h0, 6'h2A, 6'h04});
    issue(w & ~32'h04000000, 1'b0, 32'h0);
    no_write();
    issue(w | 32'h20000000, 1'b0, 32'h0);
    no_write();
    issue(mk(1'b0, 1'b0, 4'hF, {3'h0, 6'h2A, 6'h04}), 1'b0, 32'h0);
    no_write();
    // clock enable low: a valid compare must not be taken
    @(posedge clk_i);
    ce_i <= 1'b0;
    issue(w, 1'b0, 32'h0);
    no_write();
    @(posedge clk_i);
    ce_i <= 1'b1;
    wb_io(1'b1, 8'h00, 32'h0, q);
    issue(w, 1'b0, 32'h0);
    no_write();
    wb_io(1'b1, 8'h00, 32'h1, q);
    $display("test refuse done");
  endtask

  task automatic t_regs();
    logic [31:0] q;
    wb_io(1'b1, 8'h00, 32'h3, q);
    wb_io(1'b0, 8'h08, 32'h0, q);
    chk(q, 32'h0);
    cmp_case(1'b0, 1'b0, 4'h1, 32'h1, 32'h2, 9'h0, 2'h0, 23'h0);
    wb_io(1'b0, 8'h08, 32'h0, q);
    chk(q, 32'h1);
    wb_io(1'b0, 8'h0C, 32'h0, q);
    chk(q, 32'h1);
    wb_io(1'b0, 8'h10, 32'h0, q);
    chk(q, 32'h0);
    $display("test registers done");
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    t_reset();
    t_codes();
    t_ext();
    t_b2b();
    t_refuse();
    t_regs();
    end_sim();
  end

  // far above the ~180 cycles the sequence needs
  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    end_sim();
  end
endmodule
